//--- ts_port_pkg.sv
// constants and types for the card transport stream port
// How it works
// - sample input bus and start on input clock
// - drive output bus for host rising-edge capture
// - output clock derived from input clock
// - start strobe only with first header byte
// - single-stream accepts contiguous or gapped packets
// - output packets contiguous when input contiguous
// - delay variation bounded by gaps plus two
// - gap is input edge without valid
// - works with 110 ns byte clock
// - clear scrambling bits of every packet when enabled; no payload descrambling
// - card packet is 200 contiguous bytes
// - multi-stream packets pass with fixed latency
// - frame 200 bytes (188 in single-stream), then discard until start
// - short packets passed cut and counted, without shifting others
// - stream tag passes through unaltered
// - spare bytes default zero, ignored
// - host spare word returned unmodified
// - local time stamp carried unchanged
// - card spare word zero or card data
// - recompute crc when card spare modified
package ts_port_pkg;
  localparam int PKT_BYTES = 200;
  localparam int HDR_BYTES = 12;
  localparam int CRC_SPAN = 11;
  localparam int TS_BYTES = 188;
  localparam int CNT_W = 8;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] SPARE_DEFAULT = 8'h00;
  localparam logic [7:0] SYNC_BYTE = 8'h47;
  localparam logic [CNT_W-1:0] CARD_SPARE_HI_IDX = 8'h07;
  localparam logic [CNT_W-1:0] CARD_SPARE_LO_IDX = 8'h08;
  localparam logic [CNT_W-1:0] CRC_IDX = 8'h0B;
  localparam logic [CNT_W-1:0] TS_HDR3_IDX = 8'h0F;
  localparam logic [CNT_W-1:0] SS_HDR3_IDX = 8'h03;
  localparam logic [CNT_W-1:0] LAST_IDX = 8'hC7;
  localparam logic [CNT_W-1:0] SS_LAST_IDX = 8'hBB;
  localparam int SCRAM_HI = 7;
  localparam int SCRAM_LO = 6;
  typedef enum logic [1:0] {
    FR_HUNT = 2'b00,
    FR_PACKET = 2'b01,
    FR_WAIT = 2'b11
  } frame_state_t;
endpackage

//--- card_transport_stream_port.sv
// transport stream port of the card: framing, pass-through and spare-word stamping
`timescale 1ns/100ps
module card_transport_stream_port #(
  parameter logic [7:0] CRC_POLY_P = ts_port_pkg::CRC_POLY,
  parameter logic [7:0] CRC_INIT_P = ts_port_pkg::CRC_INIT
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_input_byte_clock,
  input wire logic [7:0] i_input_byte_bus,
  input wire logic i_input_packet_start,
  input wire logic i_input_byte_valid,
  input wire logic i_multi_mode,
  input wire logic i_descramble_enable,
  input wire logic i_card_spare_enable,
  input wire logic [15:0] i_card_spare_word,
  output logic o_output_byte_clock,
  output logic [7:0] o_output_byte_bus,
  output logic o_output_packet_start,
  output logic o_link_reset_done,
  output logic [15:0] o_dropped_count
);
  import ts_port_pkg::*;

  // control levels cross into the link domain through two flops
  logic [2:0] ctl_meta;
  logic [2:0] ctl_sync;
  logic [15:0] spare_meta;
  logic [15:0] spare_sync;
  logic [1:0] rst_meta;
  logic link_rst;
  always_ff @(posedge i_input_byte_clock) begin
    rst_meta <= {rst_meta[0], i_srst};
    ctl_meta <= {i_card_spare_enable, i_descramble_enable, i_multi_mode};
    ctl_sync <= ctl_meta;
    spare_meta <= i_card_spare_word;
    spare_sync <= spare_meta;
  end
  assign link_rst = rst_meta[1];
  wire multi_mode = ctl_sync[0];
  wire descram_on = ctl_sync[1];
  wire spare_on = ctl_sync[2];

  // output clock is the input clock itself, so no independent source
  assign o_output_byte_clock = i_input_byte_clock;

  // input pins registered once on the link clock
  logic [7:0] in_byte;
  logic in_start;
  logic in_valid;
  always_ff @(posedge i_input_byte_clock) begin
    in_byte <= i_input_byte_bus;
    in_start <= i_input_packet_start;
    in_valid <= i_input_byte_valid;
  end

  // single-stream bytes count only while valid; a gap just stalls the stream
  wire byte_take = multi_mode | in_valid;

  frame_state_t state;
  frame_state_t next_state;
  logic [CNT_W-1:0] idx;
  logic [CNT_W-1:0] next_idx;
  logic [CNT_W-1:0] last_idx;
  assign last_idx = multi_mode ? LAST_IDX : SS_LAST_IDX;
  wire at_last = idx == last_idx;

  // a fresh start always wins, so a short packet is cut with no latency shift
  always_comb begin
    next_state = state;
    next_idx = idx;
    case (state)
      FR_PACKET: begin
        if (byte_take & in_start) begin
          next_idx = '0;
        end else if (byte_take & at_last) begin
          next_state = FR_WAIT;
        end else if (byte_take) begin
          next_idx = idx + 1'b1;
        end
      end
      FR_HUNT, FR_WAIT: begin
        if (byte_take & in_start) begin
          next_state = FR_PACKET;
          next_idx = '0;
        end else if (byte_take) begin
          next_state = FR_WAIT;
        end
      end
      default: begin
        next_state = FR_HUNT;
        next_idx = '0;
      end
    endcase
  end

  always_ff @(posedge i_input_byte_clock) begin
    if (link_rst) begin
      state <= FR_HUNT;
      idx <= '0;
    end else begin
      state <= next_state;
      idx <= next_idx;
    end
  end

  wire in_pkt = byte_take & (in_start | (state == FR_PACKET & ~at_last));
  logic [CNT_W-1:0] cur_idx;
  assign cur_idx = in_start ? '0 : idx + 1'b1;

  // a cut packet is one whose strobe arrives before the last byte
  wire short_cut = byte_take & in_start & (state == FR_PACKET) & ~at_last;

  // crc over first eleven pre-header bytes, msb first
  function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int b = 0; b < 8; b++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY_P) : (c << 1);
    end
    return c;
  endfunction

  logic [7:0] crc;
  wire stamp = multi_mode & spare_on;
  wire is_spare_hi = multi_mode & cur_idx == CARD_SPARE_HI_IDX;
  wire is_spare_lo = multi_mode & cur_idx == CARD_SPARE_LO_IDX;
  wire is_crc = multi_mode & cur_idx == CRC_IDX;
  wire is_scram = cur_idx == (multi_mode ? TS_HDR3_IDX : SS_HDR3_IDX);

  // tag, time stamp, host spare and spare bytes pass through untouched
  logic [7:0] out_sel;
  always_comb begin
    out_sel = in_byte;
    if (stamp & is_spare_hi) begin
      out_sel = spare_sync[15:8];
    end else if (stamp & is_spare_lo) begin
      out_sel = spare_sync[7:0];
    end else if (stamp & is_crc) begin
      out_sel = crc;
    end else if (descram_on & is_scram) begin
      // payload keys live outside this block; only control bits are cleared
      out_sel = {2'b00, in_byte[SCRAM_LO-1:0]};
    end
  end

  always_ff @(posedge i_input_byte_clock) begin
    if (link_rst) begin
      crc <= CRC_INIT_P;
    end else if (in_pkt & in_start) begin
      crc <= crc_step(CRC_INIT_P, in_byte);
    end else if (in_pkt & cur_idx < CRC_IDX) begin
      crc <= crc_step(crc, out_sel);
    end
  end

  // fixed two-cycle latency in multi-stream mode; single-stream gaps pass as idle cycles
  always_ff @(posedge i_input_byte_clock) begin
    if (link_rst) begin
      o_output_byte_bus <= SPARE_DEFAULT;
      o_output_packet_start <= 1'b0;
    end else begin
      o_output_byte_bus <= in_pkt ? out_sel : SPARE_DEFAULT;
      o_output_packet_start <= in_pkt & in_start;
    end
  end
  // fixed two-cycle path keeps variation under two periods
  // no stream is originated here; output timing always follows the input

  logic [15:0] dropped;
  always_ff @(posedge i_input_byte_clock) begin
    if (link_rst) begin
      dropped <= '0;
    end else if (short_cut) begin
      dropped <= dropped + 1'b1;
    end
  end

  // drop count crosses back as a gray-coded count, reset done as a synced bit
  logic [15:0] drop_gray;
  logic [15:0] gray_meta;
  logic [15:0] gray_sync;
  logic rst_seen_meta;
  logic rst_seen;
  logic link_up;
  always_ff @(posedge i_input_byte_clock) begin
    drop_gray <= dropped ^ (dropped >> 1);
    link_up <= ~link_rst;
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      gray_meta <= '0;
      gray_sync <= '0;
      rst_seen_meta <= 1'b0;
      rst_seen <= 1'b0;
    end else begin
      gray_meta <= drop_gray;
      gray_sync <= gray_meta;
      rst_seen_meta <= link_up;
      rst_seen <= rst_seen_meta;
    end
  end
  always_comb begin
    o_dropped_count[15] = gray_sync[15];
    for (int k = 14; k >= 0; k--) begin
      o_dropped_count[k] = o_dropped_count[k + 1] ^ gray_sync[k];
    end
  end
  assign o_link_reset_done = rst_seen;
endmodule // card_transport_stream_port

//--- ts_port_asserts.sv
// concurrent checks on the link side of the transport stream port
`timescale 1ns/100ps
module ts_port_asserts (
  input wire logic i_srst,
  input wire logic i_input_byte_clock,
  input wire logic [7:0] i_input_byte_bus,
  input wire logic i_input_packet_start,
  input wire logic i_multi_mode,
  input wire logic i_descramble_enable,
  input wire logic i_card_spare_enable,
  input wire logic [15:0] i_card_spare_word,
  input wire logic [7:0] o_output_byte_bus,
  input wire logic o_output_packet_start
);
  // byte index since output start, parked at ff when idle
  logic [7:0] cnt;
  wire mod_b = (i_card_spare_enable && cnt inside {8'h07, 8'h08, 8'h0B})
    || (i_descramble_enable && cnt == 8'h0F);
  always_ff @(posedge i_input_byte_clock) begin
    if (i_srst) cnt <= 8'hFF;
    else if (o_output_packet_start) cnt <= 8'h01;
    else if (cnt != 8'hFF) cnt <= cnt + 8'h01;
  end
  default clocking @(posedge i_input_byte_clock); endclocking
  default disable iff (i_srst);
  sequence s_lat; ##2 o_output_packet_start; endsequence
  property p_lat; i_multi_mode && i_input_packet_start |-> s_lat; endproperty
  a_lat: assert property (p_lat) else $error("start late");
  property p_only; o_output_packet_start |-> $past(i_input_packet_start, 2); endproperty
  a_only: assert property (p_only) else $error("stray start");
  property p_pass; cnt < 8'hC8 && !mod_b
    |-> o_output_byte_bus == $past(i_input_byte_bus, 2); endproperty
  a_pass: assert property (p_pass) else $error("byte altered");
  property p_idle; cnt > 8'hC7 && !o_output_packet_start |-> o_output_byte_bus == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("bus not idle");
  property p_hi; i_card_spare_enable && cnt == 8'h07 && !o_output_packet_start
    |-> o_output_byte_bus == i_card_spare_word[15:8]; endproperty
  a_hi: assert property (p_hi) else $error("spare hi");
  property p_lo; i_card_spare_enable && cnt == 8'h08 && !o_output_packet_start
    |-> o_output_byte_bus == i_card_spare_word[7:0]; endproperty
  a_lo: assert property (p_lo) else $error("spare lo");
  property p_desc; i_descramble_enable && cnt == 8'h0F && !o_output_packet_start
    |-> o_output_byte_bus == ($past(i_input_byte_bus, 2) & 8'h3F); endproperty
  a_desc: assert property (p_desc) else $error("scramble bits");
  property p_run; o_output_packet_start |=> !o_output_packet_start [*8]; endproperty
  a_run: assert property (p_run) else $error("start too soon");
endmodule // ts_port_asserts
bind card_transport_stream_port ts_port_asserts ts_port_asserts_i (.i_srst,
  .i_input_byte_clock, .i_input_byte_bus, .i_input_packet_start, .i_multi_mode,
  .i_descramble_enable, .i_card_spare_enable, .i_card_spare_word, .o_output_byte_bus,
  .o_output_packet_start);

//--- ts_host_source.sv
// host model: free byte clock and card packet source
`timescale 1ns/100ps
module ts_host_source (
  output logic o_clk,
  output logic [7:0] o_bus,
  output logic o_start,
  output logic o_valid
);
  import ts_port_pkg::*;
  initial begin
    o_clk = 1'b0;
    o_bus = 8'h00;
    o_start = 1'b0;
    o_valid = 1'b0;
    #3.7;
    forever #6 o_clk = ~o_clk; // free running
  end
  function automatic logic [7:0] crc8(input logic [7:0] b [PKT_BYTES]);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 0; i < CRC_SPAN; i++) begin
      c ^= b[i];
      repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ CRC_POLY : {c[6:0], 1'b0};
    end
    return c;
  endfunction
  // gap bytes are random, and valid is random on every cycle, gaps included
  task automatic send(input logic [7:0] b [PKT_BYTES], input int len, input int gap);
    for (int i = 0; i < len + gap; i++) begin
      @(posedge o_clk);
      o_start <= (i == 0);
      o_bus <= (i < len) ? b[i] : 8'($urandom);
      o_valid <= 1'($urandom);
    end
  endtask
endmodule // ts_host_source

//--- card_transport_stream_port_bench.sv
// self-checking bench for the card transport stream port
`timescale 1ns/100ps
module card_transport_stream_port_bench;
  import ts_port_pkg::*;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic desc = 1'b0;
  logic spare_en = 1'b0;
  logic [15:0] spare = 16'h0000;
  logic lclk, istart, ival, ostart, oclk, done;
  logic [7:0] ibus, obus;
  logic [15:0] drops;
  logic [7:0] pkt [PKT_BYTES];
  logic [7:0] e [PKT_BYTES];
  logic [7:0] got [PKT_BYTES];
  logic [7:0] q [$];
  int fails = 0;
  int samples_checked = 0;
  int n = PKT_BYTES;
  int shorts = 0;
  ts_host_source ts_host_source_i (.o_clk(lclk), .o_bus(ibus), .o_start(istart),
    .o_valid(ival));
  card_transport_stream_port card_transport_stream_port_i (.i_clk(i_clk), .i_srst(i_srst),
    .i_input_byte_clock(lclk), .i_input_byte_bus(ibus), .i_input_packet_start(istart),
    .i_input_byte_valid(ival), .i_multi_mode(1'b1), .i_descramble_enable(desc),
    .i_card_spare_enable(spare_en), .i_card_spare_word(spare), .o_output_byte_clock(oclk),
    .o_output_byte_bus(obus), .o_output_packet_start(ostart), .o_link_reset_done(done),
    .o_dropped_count(drops));
  initial forever #2.5 i_clk = ~i_clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // only whole 200-byte output packets are compared; cut ones are let go
  always @(negedge lclk) begin
    if (ostart === 1'b1) n = 0;
    if (n < PKT_BYTES) begin
      got[n] = obus;
      n++;
      if (n == PKT_BYTES) for (int i = 0; i < PKT_BYTES; i++) begin
        check(16'(got[i]), 16'(q.pop_front()));
      end
    end
  end
  initial begin
    void'($urandom(59912));
    repeat (8) @(posedge i_clk);
    i_srst <= 1'b0;
    for (int t = 0; t < 200 && done !== 1'b1; t++) @(posedge i_clk);
    check(16'(done), 16'h0001);
    repeat (3) @(posedge lclk);
    for (int p = 0; p < 12; p++) begin
      if (p == 6) begin
        repeat (4) @(posedge lclk);
        @(posedge i_clk);
        desc <= 1'b1;
        spare_en <= 1'b1;
        spare <= 16'($urandom);
        repeat (10) @(posedge lclk);
      end
      foreach (pkt[i]) pkt[i] = 8'($urandom);
      pkt[CRC_IDX] = ts_host_source_i.crc8(pkt);
      if (p % 3 == 1) begin
        shorts++;
        ts_host_source_i.send(pkt, 9 + $urandom_range(190), 0);
      end else begin
        e = pkt;
        if (spare_en) begin
          e[CARD_SPARE_HI_IDX] = spare[15:8];
          e[CARD_SPARE_LO_IDX] = spare[7:0];
          e[CRC_IDX] = ts_host_source_i.crc8(e);
        end
        if (desc) e[TS_HDR3_IDX][7:6] = 2'b00;
        foreach (e[i]) q.push_back(e[i]);
        ts_host_source_i.send(pkt, PKT_BYTES, p % 2 ? 0 : $urandom_range(5));
      end
    end
    for (int t = 0; t < 1000 && q.size() > 0; t++) @(posedge lclk);
    repeat (20) @(posedge i_clk);
    check(drops, 16'(shorts));
    check(16'(q.size()), 16'h0000);
    stop_test();
  end
endmodule // card_transport_stream_port_bench
